// >>> escr_irq_src.sv
`timescale 1ns/1ps
// =====
// request sources: levels change off the sampling edge
module escr_irq_src (
    input  wire logic        clk_in,
    input  wire logic [31:0] lvl_in,
    output logic [31:0]      irq_out
);
    initial irq_out = 32'h0;
    always @(negedge clk_in) begin
        irq_out <= lvl_in;
    end
endmodule // escr_irq_src

// >>> escr_pkg.sv
package escr_pkg;

    // =====================================================================
    // control register indices
    // =====================================================================
    localparam logic [4:0] REG_STATUS    = 5'h00;
    localparam logic [4:0] REG_SAVED_EXC  = 5'h01;
    localparam logic [4:0] REG_SAVED_BRK  = 5'h02;
    localparam logic [4:0] REG_INT_MASK   = 5'h03;
    localparam logic [4:0] REG_INT_LEVELS = 5'h04;
    localparam logic [4:0] REG_PROC_ID    = 5'h05;
    localparam logic [4:0] REG_EXCEPTION  = 5'h07;
    localparam logic [4:0] REG_PAGE_TABLE = 5'h08;

    // =====================================================================
    // field positions and reset values
    // =====================================================================
    localparam int         POS_INT_EN     = 0;
    localparam int         POS_USER       = 1;
    localparam int         POS_HANDLER    = 2;
    localparam int         CAUSE_LSB      = 2;
    localparam int         CAUSE_W        = 5;
    localparam int         PAGE_NUM_LSB   = 2;
    localparam int         PAGE_NUM_W     = 20;
    localparam int         BASE_LSB       = 22;
    localparam int         BASE_W         = 10;
    localparam logic [2:0] STATE_RESET    = 3'h0;
    localparam logic [4:0] CAUSE_RESET    = 5'h00;
    localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
    // identifier default: arbitrary value
    localparam logic [31:0] CPU_ID_DEFAULT = 32'h0000_0000;

    // processor state word: handler, user, interrupt enable
    typedef struct packed {
        logic handler_active_flag;
        logic user_flag;
        logic global_interrupt_enable;
    } escr_state_t;

    // control-register access from the pipeline
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        supervisor;
        logic [4:0]  idx;
        logic [31:0] wdata;
    } escr_ctl_req_t;

    // exception events from the pipeline
    typedef struct packed {
        logic        take;
        logic        is_break;
        logic [4:0]  cause;
        logic        vpn_load;
        logic [19:0] virtual_page_number;
        logic        eret;
        logic        bret;
        logic        tlb_read;
        logic [19:0] tlb_vpn;
    } escr_exc_t;

endpackage

// >>> escr_regs.sv
`timescale 1ns/1ps
// Function
// - non-break exception saves state word to estate
// - saved exception state layout bits 2,1,0
// - exception return restores state from saved copy
// - break saves state word to break copy
// - saved break state layout bits 2,1,0
// - break return restores state from break copy
// - enable mask, one bit per request line
// - pending read returns live request levels
// - writes to pending register are ignored
// - identifier returns generation-time constant
// - writes to identifier are ignored
// - cause info only with extra info option, translation unit or protection unit
// - non-break exception writes highest-priority cause code
// - page-table register only with translation unit
// - hardware never writes table base field
// - page number loads on miss, violation, read
// - no exception page number load while handler active
// - state bit 0 is global interrupt enable
// - any exception sets handler active flag, with translation unit only
// - access only via control ops in supervisor
module escr_regs #(
    parameter int          NUM_IRQ     = 32,
    parameter bit          HAS_MMU     = 1'b1,
    parameter bit          HAS_MPU     = 1'b0,
    parameter bit          EXTRA_INFO  = 1'b0,
    parameter logic [31:0] CPU_ID      = escr_pkg::CPU_ID_DEFAULT  // arbitrary value
) (
    // clock and reset
    input  wire logic                   CLOCK_IN,
    input  wire logic                   RESET_IN,
    // control register access
    input  wire escr_pkg::escr_ctl_req_t CTL_REQ_IN,
    output logic [31:0]                 CTL_RDATA_OUT,
    // exception events
    input  wire escr_pkg::escr_exc_t    EXC_IN,
    // interrupt request pins
    input  wire logic [NUM_IRQ-1:0]     INTERRUPT_REQUEST_LINE_IN,
    // state and interrupt outputs
    output escr_pkg::escr_state_t       STATE_OUT,
    output logic                        IRQ_PENDING_OUT
);

    localparam bit INFO_ON = EXTRA_INFO | HAS_MMU | HAS_MPU;

    // =====================================================================
    // decode helpers
    // =====================================================================
    function automatic logic wr_hit(input logic ok, input logic [4:0] idx, input logic [4:0] target);
        return ok && (idx == target);
    endfunction

    // =====================================================================
    // request line synchroniser
    // =====================================================================
    logic [NUM_IRQ-1:0] irq_meta_ff;
    logic [NUM_IRQ-1:0] irq_sync_ff;
    logic [NUM_IRQ-1:0] nxt_irq_meta;
    logic [NUM_IRQ-1:0] nxt_irq_sync;

    always_comb begin
        nxt_irq_meta = INTERRUPT_REQUEST_LINE_IN;
        nxt_irq_sync = irq_meta_ff;
        if (RESET_IN) begin
            nxt_irq_meta = '0;
            nxt_irq_sync = '0;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        irq_meta_ff <= nxt_irq_meta;
        irq_sync_ff <= nxt_irq_sync;
    end

    // =====================================================================
    // register state
    // =====================================================================
    escr_pkg::escr_state_t status_ff;
    escr_pkg::escr_state_t saved_exc_ff;
    escr_pkg::escr_state_t saved_brk_ff;
    escr_pkg::escr_state_t nxt_status;
    escr_pkg::escr_state_t nxt_saved_exc;
    escr_pkg::escr_state_t nxt_saved_brk;
    logic [NUM_IRQ-1:0]    int_mask_ff;
    logic [NUM_IRQ-1:0]    nxt_int_mask;
    logic [4:0]            cause_ff;
    logic [4:0]            nxt_cause;
    logic [9:0]            table_base_field_ff;
    logic [9:0]            nxt_table_base_field;
    logic [19:0]           virtual_page_number_ff;
    logic [19:0]           nxt_virtual_page_number;
    logic                  wr_ok;
    logic                  rd_ok;

    function automatic escr_pkg::escr_state_t to_state(input logic [31:0] w);
        escr_pkg::escr_state_t s;
        s.handler_active_flag     = w[escr_pkg::POS_HANDLER];
        s.user_flag               = w[escr_pkg::POS_USER];
        s.global_interrupt_enable = w[escr_pkg::POS_INT_EN];
        return s;
    endfunction

    function automatic logic [31:0] from_state(input escr_pkg::escr_state_t s);
        logic [31:0] w;
        w                          = escr_pkg::WORD_RESET;
        w[escr_pkg::POS_HANDLER]   = s.handler_active_flag;
        w[escr_pkg::POS_USER]      = s.user_flag;
        w[escr_pkg::POS_INT_EN]    = s.global_interrupt_enable;
        return w;
    endfunction

    assign wr_ok = CTL_REQ_IN.wr & CTL_REQ_IN.supervisor;
    assign rd_ok = CTL_REQ_IN.rd & CTL_REQ_IN.supervisor;

    // =====================================================================
    // processor state word
    // =====================================================================
    // an exception wins over both returns, exception return over break return
    always_comb begin
        nxt_status = status_ff;
        if (wr_hit(wr_ok, CTL_REQ_IN.idx, escr_pkg::REG_STATUS)) begin
            nxt_status = to_state(CTL_REQ_IN.wdata);
        end
        if (EXC_IN.take) begin
            nxt_status.handler_active_flag     = 1'b1;
            nxt_status.user_flag               = 1'b0;
            nxt_status.global_interrupt_enable = 1'b0;
        end else if (EXC_IN.eret) begin
            nxt_status = saved_exc_ff;
        end else if (EXC_IN.bret) begin
            nxt_status = saved_brk_ff;
        end
        // handler flag only exists with a translation unit, user flag with a translation or protection unit
        if (!HAS_MMU) begin
            nxt_status.handler_active_flag = 1'b0;
        end
        if (!(HAS_MMU || HAS_MPU)) begin
            nxt_status.user_flag = 1'b0;
        end
        if (RESET_IN) begin
            nxt_status = escr_pkg::STATE_RESET;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        status_ff <= nxt_status;
    end

    // =====================================================================
    // saved copies of the state word
    // =====================================================================
    // hardware saves override a same-cycle software write
    always_comb begin
        nxt_saved_exc = saved_exc_ff;
        nxt_saved_brk = saved_brk_ff;
        if (wr_hit(wr_ok, CTL_REQ_IN.idx, escr_pkg::REG_SAVED_EXC)) begin
            nxt_saved_exc = to_state(CTL_REQ_IN.wdata);
        end
        if (wr_hit(wr_ok, CTL_REQ_IN.idx, escr_pkg::REG_SAVED_BRK)) begin
            nxt_saved_brk = to_state(CTL_REQ_IN.wdata);
        end
        if (EXC_IN.take) begin
            if (EXC_IN.is_break) begin
                nxt_saved_brk = status_ff;
            end else begin
                nxt_saved_exc = status_ff;
            end
        end
        if (RESET_IN) begin
            nxt_saved_exc = escr_pkg::STATE_RESET;
            nxt_saved_brk = escr_pkg::STATE_RESET;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        saved_exc_ff <= nxt_saved_exc;
        saved_brk_ff <= nxt_saved_brk;
    end

    // =====================================================================
    // interrupt enable mask
    // =====================================================================
    always_comb begin
        nxt_int_mask = int_mask_ff;
        if (wr_hit(wr_ok, CTL_REQ_IN.idx, escr_pkg::REG_INT_MASK)) begin
            nxt_int_mask = CTL_REQ_IN.wdata[NUM_IRQ-1:0];
        end
        if (RESET_IN) begin
            nxt_int_mask = '0;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        int_mask_ff <= nxt_int_mask;
    end

    // =====================================================================
    // exception cause
    // =====================================================================
    // read-only: no software write path exists
    always_comb begin
        nxt_cause = cause_ff;
        if (INFO_ON && EXC_IN.take && !EXC_IN.is_break) begin
            nxt_cause = EXC_IN.cause;
        end
        if (RESET_IN) begin
            nxt_cause = escr_pkg::CAUSE_RESET;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        cause_ff <= nxt_cause;
    end

    // =====================================================================
    // page-table address
    // =====================================================================
    // hardware page-number loads override a same-cycle software write
    always_comb begin
        nxt_table_base_field    = table_base_field_ff;
        nxt_virtual_page_number = virtual_page_number_ff;
        if (HAS_MMU && wr_hit(wr_ok, CTL_REQ_IN.idx, escr_pkg::REG_PAGE_TABLE)) begin
            nxt_table_base_field    = CTL_REQ_IN.wdata[escr_pkg::BASE_LSB +: escr_pkg::BASE_W];
            nxt_virtual_page_number = CTL_REQ_IN.wdata[escr_pkg::PAGE_NUM_LSB +: escr_pkg::PAGE_NUM_W];
        end
        if (HAS_MMU && EXC_IN.tlb_read) begin
            nxt_virtual_page_number = EXC_IN.tlb_vpn;
        end
        // a nested exception keeps the page number of the first one
        if (HAS_MMU && EXC_IN.take && !EXC_IN.is_break && EXC_IN.vpn_load &&
            !status_ff.handler_active_flag) begin
            nxt_virtual_page_number = EXC_IN.virtual_page_number;
        end
        if (RESET_IN) begin
            nxt_table_base_field    = '0;
            nxt_virtual_page_number = '0;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        table_base_field_ff    <= nxt_table_base_field;
        virtual_page_number_ff <= nxt_virtual_page_number;
    end

    // =====================================================================
    // read data
    // =====================================================================
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    always_comb begin
        nxt_rdata = escr_pkg::WORD_RESET;
        if (rd_ok) begin
            unique case (CTL_REQ_IN.idx)
                escr_pkg::REG_STATUS:   nxt_rdata = from_state(status_ff);
                escr_pkg::REG_SAVED_EXC:  nxt_rdata = from_state(saved_exc_ff);
                escr_pkg::REG_SAVED_BRK:  nxt_rdata = from_state(saved_brk_ff);
                escr_pkg::REG_INT_MASK:   nxt_rdata[NUM_IRQ-1:0] = int_mask_ff;
                // levels come only from the pins, so a write cannot alter them
                escr_pkg::REG_INT_LEVELS: nxt_rdata[NUM_IRQ-1:0] = irq_sync_ff;
                // a parameter, so a write cannot alter it
                escr_pkg::REG_PROC_ID:    nxt_rdata = CPU_ID;
                escr_pkg::REG_EXCEPTION: begin
                    if (INFO_ON) begin
                        nxt_rdata[escr_pkg::CAUSE_LSB +: escr_pkg::CAUSE_W] = cause_ff;
                    end
                end
                escr_pkg::REG_PAGE_TABLE: begin
                    if (HAS_MMU) begin
                        nxt_rdata[escr_pkg::BASE_LSB +: escr_pkg::BASE_W]         = table_base_field_ff;
                        nxt_rdata[escr_pkg::PAGE_NUM_LSB +: escr_pkg::PAGE_NUM_W] = virtual_page_number_ff;
                    end
                end
                default: ;
            endcase
        end
        if (RESET_IN) begin
            nxt_rdata = escr_pkg::WORD_RESET;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        rdata_ff <= nxt_rdata;
    end

    // =====================================================================
    // interrupt request to the pipeline
    // =====================================================================
    logic [NUM_IRQ-1:0] masked_req;

    assign masked_req = int_mask_ff & irq_sync_ff;

    // =====================================================================
    // outputs
    // =====================================================================
    assign CTL_RDATA_OUT   = rdata_ff;
    assign STATE_OUT       = status_ff;
    assign IRQ_PENDING_OUT = status_ff.global_interrupt_enable & (|masked_req);

endmodule // escr_regs

// >>> escr_regs_bench.sv
`timescale 1ns/1ps
module escr_regs_bench;
    logic                    clock = 1'b0;
    logic                    reset = 1'b1;
    escr_pkg::escr_ctl_req_t req;
    escr_pkg::escr_exc_t     exc;
    escr_pkg::escr_state_t   state;
    logic [31:0]             rdata, irq, irq_lvl, lfsr, m, w;
    logic                    pend;
    int                      fails = 0, n_compared = 0, cycles = 0;
    localparam logic [31:0]  ID = 32'h5A3C_0F01;  // arbitrary value
    always #20 clock = ~clock;
    escr_irq_src i_escr_irq_src (.clk_in(clock), .lvl_in(irq_lvl), .irq_out(irq));
    escr_regs #(.CPU_ID(ID)) i_escr_regs (.CLOCK_IN(clock), .RESET_IN(reset), .CTL_REQ_IN(req), .CTL_RDATA_OUT(rdata),
        .EXC_IN(exc), .INTERRUPT_REQUEST_LINE_IN(irq), .STATE_OUT(state), .IRQ_PENDING_OUT(pend));
    // =====
    // tasks
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] i, input logic [31:0] d, input logic s);
        @(negedge clock) req = {2'b01, s, i, d};
        @(negedge clock) req = '0;
    endtask
    task automatic rd(input logic [4:0] i, input logic [31:0] e);
        @(negedge clock) req = {3'b101, i, 32'h0};
        @(negedge clock) req = '0;
        chk(rdata, e);
    endtask
    task automatic ev(input logic [1:0] tk, input logic [2:0] rt, input logic ld, input logic [19:0] v);
        @(negedge clock) exc = {tk, lfsr[4:0], ld, v, rt, v};
        @(negedge clock) exc = '0;
    endtask
    task automatic final_report;
        $display("compared=%0d fails=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            final_report;
        end
    end
    // =====
    // main sequence
    initial begin
        req = '0;
        exc = '0;
        irq_lvl = 32'h0;
        lfsr = 32'h0000_0061;
        repeat (12) @(negedge clock);
        reset = 1'b0;
        for (int k = 0; k < 9; k++) rd(5'(k), (k == 5) ? ID : 32'h0);
        $display("reset test done");
        m = nxt(lfsr);
        wr(escr_pkg::REG_INT_MASK, m, 1'b1);
        wr(escr_pkg::REG_INT_MASK, ~m, 1'b0);
        rd(escr_pkg::REG_INT_MASK, m);
        wr(escr_pkg::REG_INT_LEVELS, 32'hFFFF_FFFF, 1'b1);
        wr(escr_pkg::REG_PROC_ID, 32'hFFFF_FFFF, 1'b1);
        rd(escr_pkg::REG_INT_LEVELS, 32'h0);
        rd(escr_pkg::REG_PROC_ID, ID);
        for (int k = 0; k < 8; k++) begin
            lfsr = nxt(lfsr);
            irq_lvl = lfsr & (32'h8000_0001 << (k * 4));
            wr(escr_pkg::REG_STATUS, {31'h0, lfsr[9]}, 1'b1);
            repeat (3) @(negedge clock);
            rd(escr_pkg::REG_INT_LEVELS, irq_lvl);
            chk(32'(pend), 32'(lfsr[9] & |(m & irq_lvl)));
        end
        irq_lvl = 32'h0;
        $display("interrupt test done");
        w = nxt(lfsr);
        lfsr = nxt(w);
        wr(escr_pkg::REG_PAGE_TABLE, w, 1'b1);
        rd(escr_pkg::REG_PAGE_TABLE, w & 32'hFFFF_FFFC);
        wr(escr_pkg::REG_STATUS, 32'h3, 1'b1);
        ev(2'b10, 3'b000, 1'b1, lfsr[19:0]);
        chk(32'(state), 32'h4);
        rd(escr_pkg::REG_SAVED_EXC, 32'h3);
        rd(escr_pkg::REG_EXCEPTION, {25'h0, lfsr[4:0], 2'b00});
        rd(escr_pkg::REG_PAGE_TABLE, {w[31:22], lfsr[19:0], 2'b00});
        ev(2'b10, 3'b000, 1'b1, ~lfsr[19:0]);
        rd(escr_pkg::REG_PAGE_TABLE, {w[31:22], lfsr[19:0], 2'b00});
        ev(2'b00, 3'b001, 1'b0, w[21:2] ^ 20'hA5A5A);
        rd(escr_pkg::REG_PAGE_TABLE, {w[31:22], w[21:2] ^ 20'hA5A5A, 2'b00});
        wr(escr_pkg::REG_SAVED_EXC, 32'h3, 1'b1);
        ev(2'b00, 3'b100, 1'b0, 20'h0);
        chk(32'(state), 32'h3);
        $display("exception test done");
        wr(escr_pkg::REG_STATUS, 32'h1, 1'b1);
        ev(2'b11, 3'b000, 1'b0, 20'h0);
        chk(32'(state.handler_active_flag), 32'h1);
        rd(escr_pkg::REG_SAVED_BRK, 32'h1);
        rd(escr_pkg::REG_SAVED_EXC, 32'h3);
        ev(2'b00, 3'b010, 1'b0, 20'h0);
        chk(32'(state), 32'h1);
        $display("break test done");
        final_report;
    end
endmodule // escr_regs_bench
bind escr_regs escr_regs_sva #(.NUM_IRQ(NUM_IRQ), .CPU_ID(CPU_ID)) i_escr_regs_sva (
    .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .CTL_REQ_IN(CTL_REQ_IN), .CTL_RDATA_OUT(CTL_RDATA_OUT),
    .EXC_IN(EXC_IN), .INTERRUPT_REQUEST_LINE_IN(INTERRUPT_REQUEST_LINE_IN), .STATE_OUT(STATE_OUT),
    .IRQ_PENDING_OUT(IRQ_PENDING_OUT));

// >>> escr_regs_sva.sv
`timescale 1ns/1ps
module escr_regs_sva #(
    parameter int          NUM_IRQ = 32,
    parameter logic [31:0] CPU_ID  = 32'h0000_0000
) (
    input wire logic                    CLOCK_IN,
    input wire logic                    RESET_IN,
    input wire escr_pkg::escr_ctl_req_t CTL_REQ_IN,
    input wire logic [31:0]             CTL_RDATA_OUT,
    input wire escr_pkg::escr_exc_t     EXC_IN,
    input wire logic [NUM_IRQ-1:0]      INTERRUPT_REQUEST_LINE_IN,
    input wire escr_pkg::escr_state_t   STATE_OUT,
    input wire logic                    IRQ_PENDING_OUT
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);
    logic [4:0] i;
    logic       r;
    assign i = CTL_REQ_IN.idx;
    assign r = CTL_REQ_IN.rd & CTL_REQ_IN.supervisor;
    // =====
    // properties
    property p_hnd; EXC_IN.take |=> STATE_OUT.handler_active_flag; endproperty
    property p_pie; EXC_IN.take && !EXC_IN.is_break |=> !STATE_OUT.global_interrupt_enable; endproperty
    property p_est; r && i == escr_pkg::REG_SAVED_EXC |=> CTL_RDATA_OUT[31:3] == 29'h0; endproperty
    property p_bst; r && i == escr_pkg::REG_SAVED_BRK |=> CTL_RDATA_OUT[31:3] == 29'h0; endproperty
    property p_pnd;
        r && i == escr_pkg::REG_INT_LEVELS && !$past(RESET_IN) && !$past(RESET_IN, 2) &&
        $stable(INTERRUPT_REQUEST_LINE_IN) && $past(INTERRUPT_REQUEST_LINE_IN, 2) == INTERRUPT_REQUEST_LINE_IN
        |=> CTL_RDATA_OUT == 32'($past(INTERRUPT_REQUEST_LINE_IN));
    endproperty
    property p_cpu; r && i == escr_pkg::REG_PROC_ID |=> CTL_RDATA_OUT == CPU_ID; endproperty
    property p_idl; !r |=> CTL_RDATA_OUT == 32'h0; endproperty
    property p_irq; IRQ_PENDING_OUT |-> STATE_OUT.global_interrupt_enable; endproperty
    property p_cau;
        r && i == escr_pkg::REG_EXCEPTION |=> CTL_RDATA_OUT[31:7] == 25'h0 && CTL_RDATA_OUT[1:0] == 2'h0;
    endproperty
    a_hnd: assert property (p_hnd) else $error("handler flag not set");
    a_pie: assert property (p_pie) else $error("interrupt enable kept");
    a_est: assert property (p_est) else $error("saved state upper bits");
    a_bst: assert property (p_bst) else $error("break state upper bits");
    a_pnd: assert property (p_pnd) else $error("request levels wrong");
    a_cpu: assert property (p_cpu) else $error("identifier wrong");
    a_idl: assert property (p_idl) else $error("read data not idle");
    a_irq: assert property (p_irq) else $error("pending without enable");
    a_cau: assert property (p_cau) else $error("cause layout wrong");
    c_exc: cover property (EXC_IN.take && !EXC_IN.is_break);
    c_brk: cover property (EXC_IN.take && EXC_IN.is_break);
    c_irq: cover property (IRQ_PENDING_OUT);
endmodule // escr_regs_sva
